// ==== core/ots_selector.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module ots_selector
	import ots_pkg::*;
#(
	parameter int P_MS_CYCLES = `OTS_MS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Terminals: bit 0 forward run, high while tied to common return
	input wire logic [`OTS_TERMINALS-1:0] i_input_common_return,
	// Packed BCD polarity digits; lowest digit is the forward run input
	input wire logic [19:0] i_polarity_one,
	input wire logic [11:0] i_polarity_two,
	// Function select writes
	input wire ots_func_t i_relay_one_function_select,
	input wire logic i_relay_one_select_we,
	input wire ots_func_t i_relay_two_function_select,
	input wire logic i_relay_two_select_we,
	// Drive state flags
	input wire logic i_drive_running,
	input wire logic i_fault_stop,
	input wire logic i_frequency_detect_level_one,
	input wire logic i_frequency_detect_level_two,
	input wire logic i_freq_reached,
	input wire logic i_motor_prewarn,
	input wire logic i_overload_eta_valid,
	input wire ots_val_t i_overload_eta_s,
	input wire logic i_speed_mode,
	input wire logic i_torque_at_limit,
	input wire logic i_stall_protect,
	input wire logic i_main_stable,
	input wire logic i_control_stable,
	input wire logic i_fault_detected,
	input wire logic i_run_cmd_ready,
	input wire logic i_undervolt,
	input wire logic [1:0] i_comms_value,
	input wire logic i_simple_sequence_program_done,
	// Values compared here
	input wire ots_val_t i_output_freq,
	input wire ots_val_t i_set_freq,
	input wire ots_val_t i_upper_limit,
	input wire ots_val_t i_lower_limit,
	input wire ots_val_t i_count_value,
	input wire ots_val_t i_set_count,
	input wire ots_val_t i_designated_count,
	input wire ots_val_t i_actual_length,
	input wire ots_val_t i_length_setpoint,
	input wire ots_val_t i_run_time,
	input wire ots_val_t i_run_time_limit,
	input wire ots_val_t i_power_on_time_counter,
	input wire ots_val_t i_power_on_limit,
	input wire ots_val_t i_voltage_analog_input,
	input wire ots_val_t i_current_analog_input,
	// Results
	output logic [`OTS_TERMINALS-1:0] o_terminal_active,
	output logic o_relay_one,
	output logic o_second_relay_contacts,
	output ots_func_t o_relay_one_function_select,
	output ots_func_t o_relay_two_function_select
);
	localparam ots_val_t PREWARN_S = 16'(`OTS_PREWARN_S);
	localparam ots_val_t FREQ_ZERO = 16'h0000;

	logic [`OTS_TERMINALS-1:0] term_q;
	logic relay_one_q, relay_two_q;
	ots_func_t sel_one_q, sel_two_q;
	logic [`OTS_TERMINALS*4-1:0] pol_digits;
	wire [`OTS_TERMINALS-1:0] term_d;
	logic [`OTS_STATUS_W-1:0] st_one, st_two;
	wire [1:0] relay_d;
	logic seq_pulse;

	// Polarity digits laid out per terminal, forward run first
	assign pol_digits = {i_polarity_two, i_polarity_one};

	// Per-terminal sense; any digit other than one counts as active-high
	genvar t;
	generate
		for (t = 0; t < `OTS_TERMINALS; t++) begin : g_term
			wire low_valid = (pol_digits[t*4 +: 4] == `OTS_POL_ACTIVE_LOW);
			assign term_d[t] = low_valid ? !i_input_common_return[t]
				: i_input_common_return[t];
		end
	endgenerate

	// Stopped is the plain inverse of running
	wire stopped = !i_drive_running;
	wire freq_zero = (i_output_freq == FREQ_ZERO);

	// Comparisons against configured thresholds, and of voltage input against current input
	wire set_count_hit = (i_count_value >= i_set_count);
	wire desig_count_hit = (i_count_value >= i_designated_count);
	wire length_hit = (i_actual_length > i_length_setpoint);
	wire run_time_hit = (i_run_time > i_run_time_limit);
	wire power_on_hit = (i_power_on_time_counter > i_power_on_limit);
	wire volt_gt_cur = (i_voltage_analog_input > i_current_analog_input);

	// Frequency limit conditions
	wire at_upper = (i_output_freq >= i_upper_limit);
	wire at_lower = (i_output_freq <= i_lower_limit);
	wire set_above = (i_set_freq > i_upper_limit);
	wire set_below = (i_set_freq < i_lower_limit);
	wire freq_limited = (set_above && at_upper) || (set_below && at_lower);

	// Estimate arrives from the overload model; ten seconds or less lights it
	wire drive_prewarn = i_overload_eta_valid && (i_overload_eta_s <= PREWARN_S);

	// Readiness needs both circuits stable and no fault seen
	wire ready = i_main_stable && i_control_stable && !i_fault_detected
		&& i_run_cmd_ready;

	// Torque limit only counts in speed control with stall active
	wire torque_limited = i_speed_mode && i_torque_at_limit && i_stall_protect;

	// Sequence cycle pulse stretched to its fixed width
	ots_cycle_pulse #(
		.P_MS_CYCLES(P_MS_CYCLES)
	) u_cycle_pulse (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_cycle_done(i_simple_sequence_program_done),
		.o_pulse(seq_pulse)
	);

	// Shared status vector; code positions without a source stay zero
	function automatic logic [`OTS_STATUS_W-1:0] build_status(input logic comms);
		logic [`OTS_STATUS_W-1:0] s;
		s = '0;
		s[`OTS_FN_RUNNING] = i_drive_running;
		s[`OTS_FN_FAULT_STOP] = i_fault_stop;
		s[`OTS_FN_FREQ_DETECT_ONE] = i_frequency_detect_level_one;
		s[`OTS_FN_FREQ_REACHED] = i_freq_reached;
		s[`OTS_FN_ZERO_SPEED] = i_drive_running && freq_zero;
		s[`OTS_FN_MOTOR_PREWARN] = i_motor_prewarn;
		s[`OTS_FN_DRIVE_PREWARN] = drive_prewarn;
		s[`OTS_FN_SET_COUNT] = set_count_hit;
		s[`OTS_FN_DESIG_COUNT] = desig_count_hit;
		s[`OTS_FN_LENGTH] = length_hit;
		s[`OTS_FN_SEQ_CYCLE] = seq_pulse;
		s[`OTS_FN_RUN_TIME] = run_time_hit;
		s[`OTS_FN_FREQ_LIMITED] = freq_limited;
		s[`OTS_FN_TORQUE_LIMITED] = torque_limited;
		s[`OTS_FN_READY] = ready;
		s[`OTS_FN_VOLT_GT_CUR] = volt_gt_cur;
		s[`OTS_FN_UPPER_LIMIT] = at_upper;
		s[`OTS_FN_LOWER_LIMIT] = i_drive_running && at_lower;
		s[`OTS_FN_UNDERVOLT] = i_undervolt;
		s[`OTS_FN_COMMS] = comms;
		s[`OTS_FN_ZERO_SPEED_2] = freq_zero || stopped;
		s[`OTS_FN_POWER_ON_TIME] = power_on_hit;
		s[`OTS_FN_FREQ_DETECT_TWO] = i_frequency_detect_level_two;
		return s;
	endfunction

	// Only the comms bit differs; a process so flags read inside the function retrigger it
	always_comb begin
		st_one = build_status(i_comms_value[0]);
		st_two = build_status(i_comms_value[1]);
	end

	// One selector per relay
	ots_relay_mux u_mux_one (
		.i_status(st_one),
		.i_code(sel_one_q),
		.o_active(relay_d[0])
	);
	ots_relay_mux u_mux_two (
		.i_status(st_two),
		.i_code(sel_two_q),
		.o_active(relay_d[1])
	);

	// Function selects keep their defaults until written
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_one_q <= `OTS_RELAY_ONE_RESET;
			sel_two_q <= `OTS_RELAY_TWO_RESET;
		end else begin
			if (i_relay_one_select_we) sel_one_q <= i_relay_one_function_select;
			if (i_relay_two_select_we) sel_two_q <= i_relay_two_function_select;
		end
	end

	// Registered outputs cost one cycle but keep relay drive glitch free
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			term_q <= '0;
			relay_one_q <= 1'b0;
			relay_two_q <= 1'b0;
		end else begin
			term_q <= term_d;
			relay_one_q <= relay_d[0];
			relay_two_q <= relay_d[1];
		end
	end

	assign o_terminal_active = term_q;
	assign o_relay_one = relay_one_q;
	assign o_second_relay_contacts = relay_two_q;
	assign o_relay_one_function_select = sel_one_q;
	assign o_relay_two_function_select = sel_two_q;
endmodule // ots_selector
`default_nettype wire

// ==== core/ots_defines.svh ====
// Behaviour
// - Polarity zero: tied to common means active
// - Two relays; reset codes two and one
// - Code 0 holds the relay inactive
// - Code 1 follows running, zero frequency included
// - Code 2 shows stop by fault
// - Code 5 zero-speed running, off at stop
// - Code 6 shows motor overload pre-warning
// - Code 7 on ten seconds before overload
// - Codes 8/9 show set/designated count reached
// - Code 10 shows actual length beyond setpoint
// - Code 11 gives 250 ms cycle pulse
// - Code 12 shows running time beyond threshold
// - Code 13 shows frequency held at limit
// - Code 14 shows torque limit with stall
// - Code 15 shows drive ready for run
// - Code 16 shows voltage input above current
// - Code 17 shows upper frequency limit reached
// - Code 18 lower limit reached, off at stop
// - Code 19 shows undervoltage state
// - Code 20 follows comms; 21, 22 reserved
// - Code 23 zero frequency, also on at stop
// - Code 24 shows power-on time beyond threshold
// - One polarity digit per input terminal
`ifndef OTS_DEFINES_SVH
`define OTS_DEFINES_SVH

// Function select codes, also bit positions in the status vector
`define OTS_FN_NONE 0
`define OTS_FN_RUNNING 1
`define OTS_FN_FAULT_STOP 2
`define OTS_FN_FREQ_DETECT_ONE 3
`define OTS_FN_FREQ_REACHED 4
`define OTS_FN_ZERO_SPEED 5
`define OTS_FN_MOTOR_PREWARN 6
`define OTS_FN_DRIVE_PREWARN 7
`define OTS_FN_SET_COUNT 8
`define OTS_FN_DESIG_COUNT 9
`define OTS_FN_LENGTH 10
`define OTS_FN_SEQ_CYCLE 11
`define OTS_FN_RUN_TIME 12
`define OTS_FN_FREQ_LIMITED 13
`define OTS_FN_TORQUE_LIMITED 14
`define OTS_FN_READY 15
`define OTS_FN_VOLT_GT_CUR 16
`define OTS_FN_UPPER_LIMIT 17
`define OTS_FN_LOWER_LIMIT 18
`define OTS_FN_UNDERVOLT 19
`define OTS_FN_COMMS 20
`define OTS_FN_ZERO_SPEED_2 23
`define OTS_FN_POWER_ON_TIME 24
`define OTS_FN_FREQ_DETECT_TWO 25
`define OTS_STATUS_W 64

// Reset values of the two function selects
`define OTS_RELAY_ONE_RESET 6'h02
`define OTS_RELAY_TWO_RESET 6'h01

// Input terminal count and polarity digit that means active-low
`define OTS_TERMINALS 8
`define OTS_DIGITS_ONE 5
`define OTS_POL_ACTIVE_LOW 4'h1

// Timing
`define OTS_CLK_HZ 100000000
`define OTS_MS_CYCLES (`OTS_CLK_HZ / 1000)
`define OTS_PULSE_MS 250
`define OTS_PREWARN_S 10

`endif

// ==== core/ots_pkg.sv ====
package ots_pkg;
	// Pulse timer states, one-hot
	typedef enum logic [1:0] {
		OTS_PULSE_IDLE = 2'b01,
		OTS_PULSE_BUSY = 2'b10
	} ots_pulse_state_t;
	typedef logic [5:0] ots_func_t;
	typedef logic [15:0] ots_val_t;
endpackage

// ==== core/ots_relay_mux.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module ots_relay_mux
	import ots_pkg::*;
(
	input wire logic [`OTS_STATUS_W-1:0] i_status,
	input wire ots_func_t i_code,
	output logic o_active
);
	// Codes without a source read a zero bit of the vector
	assign o_active = i_status[i_code];
endmodule // ots_relay_mux
`default_nettype wire

// ==== core/ots_cycle_pulse.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ots_defines.svh"
module ots_cycle_pulse
	import ots_pkg::*;
#(
	parameter int P_MS_CYCLES = `OTS_MS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_cycle_done,
	output logic o_pulse
);
	localparam int CW = $clog2(P_MS_CYCLES + 1);
	localparam logic [CW-1:0] MS_LAST = CW'(P_MS_CYCLES - 1);
	localparam logic [7:0] PULSE_LAST = 8'(`OTS_PULSE_MS - 1);
	ots_pulse_state_t state_q, state_d;
	logic [CW-1:0] div_q;
	logic [7:0] ms_q;
	wire ms_tick = (div_q == MS_LAST);
	wire done = ms_tick && (ms_q == PULSE_LAST);

	// Divider restarts on a trigger so the width is exact
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_q <= '0;
			ms_q <= 8'h00;
		end else if (i_cycle_done || state_q == OTS_PULSE_IDLE) begin
			div_q <= '0;
			ms_q <= 8'h00;
		end else if (ms_tick) begin
			div_q <= '0;
			ms_q <= ms_q + 8'h01;
		end else begin
			div_q <= div_q + CW'(1);
		end
	end

	// A new cycle end while busy restarts the pulse rather than merging
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			OTS_PULSE_IDLE: begin
				if (i_cycle_done) state_d = OTS_PULSE_BUSY;
			end
			OTS_PULSE_BUSY: begin
				if (!i_cycle_done && done) state_d = OTS_PULSE_IDLE;
			end
			default: state_d = OTS_PULSE_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) state_q <= OTS_PULSE_IDLE;
		else state_q <= state_d;
	end

	assign o_pulse = (state_q == OTS_PULSE_BUSY);
endmodule // ots_cycle_pulse
`default_nettype wire

// ==== test/ots_relay_load.sv ====
`timescale 1ns/1ns
`default_nettype none
module ots_relay_load (
	input wire logic i_mclk,
	input wire logic i_relay,
	output int o_width
);
	int run_q;
	// Closure length in cycles, latched as the coil drops out
	always_ff @(posedge i_mclk) begin
		run_q <= i_relay ? run_q + 1 : 0;
		if (!i_relay && run_q != 0) begin
			o_width <= run_q;
		end
	end
endmodule // ots_relay_load
`default_nettype wire

// ==== test/ots_selector_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module ots_selector_checker
	import ots_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_input_common_return,
	input wire logic [19:0] i_polarity_one,
	input wire ots_func_t i_relay_one_function_select,
	input wire logic i_relay_one_select_we,
	input wire logic i_drive_running,
	input wire logic i_fault_stop,
	input wire logic i_undervolt,
	input wire logic [7:0] o_terminal_active,
	input wire logic o_relay_one,
	input wire logic o_second_relay_contacts,
	input wire ots_func_t o_relay_one_function_select,
	input wire ots_func_t o_relay_two_function_select
);
	wire ots_func_t sel_one = o_relay_one_function_select;
	wire ots_func_t sel_two = o_relay_two_function_select;
	// Relays follow the held code and the flags one edge later
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	zero_code_a: assert property (sel_one == 6'h00 |=> !o_relay_one)
		else $error("relay one on with code zero");
	fault_code_a: assert property (sel_one == 6'h02 |=> o_relay_one == $past(i_fault_stop))
		else $error("relay one does not show fault stop");
	run_code_a: assert property (sel_two == 6'h01 |=>
		o_second_relay_contacts == $past(i_drive_running))
		else $error("relay two does not show running");
	stop_zero_a: assert property (sel_one == 6'h05 && !i_drive_running |=> !o_relay_one)
		else $error("zero speed code on while stopped");
	stop_on_a: assert property (sel_one == 6'h17 && !i_drive_running |=> o_relay_one)
		else $error("zero speed two off while stopped");
	undervolt_code_a: assert property (sel_two == 6'h13 |=>
		o_second_relay_contacts == $past(i_undervolt))
		else $error("relay two does not show undervoltage");
	reserved_code_a: assert property (sel_two inside {6'h15, 6'h16} |=>
		!o_second_relay_contacts)
		else $error("reserved code drives relay two");
	select_write_a: assert property (i_relay_one_select_we |=>
		sel_one == $past(i_relay_one_function_select))
		else $error("code write not taken");
	select_hold_a: assert property (!i_relay_one_select_we |=> $stable(sel_one))
		else $error("code changed without write");
	polarity_zero_a: assert property (i_polarity_one[3:0] == 4'h0 |=>
		o_terminal_active[0] == $past(i_input_common_return[0]))
		else $error("forward input sense wrong");
endmodule // ots_selector_checker
bind ots_selector ots_selector_checker u_ots_selector_checker (.*);
`default_nettype wire

// ==== test/output_terminal_status_selector_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module output_terminal_status_selector_bench
	import ots_pkg::*;
;
	localparam int P_MS_CYCLES = 4;
	logic i_mclk = '0, i_arst_n = '0, i_relay_one_select_we = '0, i_relay_two_select_we = '0;
	logic i_drive_running = '0, i_fault_stop = '0, i_frequency_detect_level_one = '0;
	logic i_frequency_detect_level_two = '0, i_freq_reached = '0, i_motor_prewarn = '0;
	logic i_overload_eta_valid = '0, i_speed_mode = '0, i_torque_at_limit = '0;
	logic i_stall_protect = '0, i_main_stable = '0, i_control_stable = '0, i_undervolt = '0;
	logic i_fault_detected = '0, i_run_cmd_ready = '0, i_simple_sequence_program_done = '0;
	logic [1:0] i_comms_value = '0;
	logic [7:0] i_input_common_return = '0;
	logic [19:0] i_polarity_one = '0;
	logic [11:0] i_polarity_two = '0;
	ots_func_t i_relay_one_function_select = '0, i_relay_two_function_select = '0;
	ots_val_t i_overload_eta_s = '0, i_output_freq = '0, i_set_freq = '0, i_upper_limit = '0;
	ots_val_t i_lower_limit = '0, i_count_value = '0, i_set_count = '0, i_designated_count = '0;
	ots_val_t i_actual_length = '0, i_length_setpoint = '0, i_run_time = '0;
	ots_val_t i_run_time_limit = '0, i_power_on_time_counter = '0, i_power_on_limit = '0;
	ots_val_t i_voltage_analog_input = '0, i_current_analog_input = '0;
	logic [7:0] o_terminal_active;
	logic o_relay_one, o_second_relay_contacts;
	ots_func_t o_relay_one_function_select, o_relay_two_function_select;
	int miscompares = 0, compares = 0, plen;
	ots_selector #(.P_MS_CYCLES(P_MS_CYCLES)) u_ots_selector (.*);
	ots_relay_load u_ots_relay_load (.i_mclk, .i_relay(o_relay_one), .o_width(plen));
	initial forever #5 i_mclk = ~i_mclk;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Reset mid-run as well, so the codes must fall back from a written value
	task automatic t_reset();
		@(negedge i_mclk);
		i_arst_n = 1'h0;
		repeat (16) @(negedge i_mclk);
		chk("select one", 16'h0002, 16'(o_relay_one_function_select));
		chk("select two", 16'h0001, 16'(o_relay_two_function_select));
		i_arst_n = 1'h1;
		$display("reset test done");
	endtask
	// Every 6-bit code on both relays; undefined ones must stay off
	task automatic sweep(input logic [63:0] e1, input logic [63:0] e2);
		for (int c = 0; c < 64; c++) begin
			i_relay_one_function_select = 6'(c);
			i_relay_two_function_select = 6'(c);
			{i_relay_one_select_we, i_relay_two_select_we} = 2'h3;
			@(negedge i_mclk);
			{i_relay_one_select_we, i_relay_two_select_we} = 2'h0;
			repeat (2) @(negedge i_mclk);
			chk("select one", 16'(c), 16'(o_relay_one_function_select));
			chk("select two", 16'(c), 16'(o_relay_two_function_select));
			chk("relay one", 16'(e1[c]), 16'(o_relay_one));
			chk("relay two", 16'(e2[c]), 16'(o_second_relay_contacts));
		end
	endtask
	// Four drive states chosen to sit on the compare boundaries
	task automatic t_codes();
		i_upper_limit = 16'h0064;
		{i_set_count, i_designated_count} = 32'h0001_0001;
		sweep(64'h0000_0000_0080_0000, 64'h0000_0000_0080_0000);
		{i_drive_running, i_fault_stop, i_frequency_detect_level_one, i_frequency_detect_level_two,
			i_freq_reached, i_motor_prewarn, i_overload_eta_valid, i_speed_mode, i_torque_at_limit,
			i_stall_protect, i_main_stable, i_control_stable, i_run_cmd_ready, i_undervolt} = 14'h3FFF;
		{i_overload_eta_s, i_count_value, i_comms_value} = {16'h000A, 16'h0001, 2'h3};
		sweep(64'h0000_0000_029C_C3FE, 64'h0000_0000_029C_C3FE);
		{i_fault_stop, i_frequency_detect_level_one, i_frequency_detect_level_two, i_freq_reached,
			i_motor_prewarn, i_stall_protect, i_undervolt} = 7'h00;
		{i_fault_detected, i_overload_eta_s} = {1'h1, 16'h000B};
		{i_count_value, i_comms_value} = {16'h0000, 2'h1};
		{i_output_freq, i_set_freq, i_lower_limit} = 48'h0064_0096_000A;
		{i_actual_length, i_length_setpoint, i_run_time, i_run_time_limit} = 64'h0003_0002_0002_0001;
		{i_power_on_time_counter, i_power_on_limit} = 32'h0005_0004;
		{i_voltage_analog_input, i_current_analog_input} = 32'h0006_0005;
		sweep(64'h0000_0000_0113_3402, 64'h0000_0000_0103_3402);
		{i_drive_running, i_output_freq} = {1'h0, 16'h0000};
		{i_set_freq, i_comms_value} = {16'h0005, 2'h2};
		{i_voltage_analog_input, i_current_analog_input} = 32'h0005_0006;
		sweep(64'h0000_0000_0180_3400, 64'h0000_0000_0190_3400);
		$display("codes test done");
	endtask
	task automatic t_polarity();
		{i_polarity_one, i_polarity_two, i_input_common_return} = 40'h0_1010_110_F0;
		@(negedge i_mclk);
		chk("terminals", 16'h003A, 16'(o_terminal_active));
		i_input_common_return = 8'h0F;
		@(negedge i_mclk);
		chk("terminals", 16'h00C5, 16'(o_terminal_active));
		{i_polarity_one, i_polarity_two} = 32'h0000_0000;
		$display("polarity test done");
	endtask
	// Cycle pulse must last exactly 250 ms of scaled time and not repeat
	task automatic t_pulse();
		int n;
		{i_relay_one_function_select, i_relay_two_function_select} = 12'h2C0;
		{i_relay_one_select_we, i_relay_two_select_we} = 2'h3;
		@(negedge i_mclk);
		{i_relay_one_select_we, i_relay_two_select_we} = 2'h0;
		i_simple_sequence_program_done = 1'h1;
		@(negedge i_mclk);
		i_simple_sequence_program_done = 1'h0;
		repeat (2) @(negedge i_mclk);
		chk("pulse start", 16'h0001, 16'(o_relay_one));
		for (n = 0; n < 2000 && o_relay_one !== 1'h0; n++) begin
			@(negedge i_mclk);
		end
		if (n == 2000) begin
			miscompares++;
			results();
		end
		repeat (20) @(negedge i_mclk);
		chk("pulse width", 16'(250 * P_MS_CYCLES), 16'(plen));
		chk("pulse after", 16'h0000, 16'(o_relay_one));
		$display("pulse test done");
	endtask
	initial begin
		t_reset();
		t_codes();
		t_polarity();
		t_pulse();
		t_reset();
		results();
	end
endmodule // output_terminal_status_selector_bench
`default_nettype wire
